// *** src/wakeup_pkg.sv ***
// Constants, register map and types for the wake-up event counter
package wakeup_pkg;
   // Clock and debounce time base
   localparam int CLK_PERIOD_NS = 4;
   localparam int UNIT_COARSE_NS = 1000000;
   localparam int UNIT_FINE_NS = 125000;
   localparam int UNIT_COARSE_CYCLES = UNIT_COARSE_NS / CLK_PERIOD_NS;
   localparam int UNIT_FINE_CYCLES = UNIT_FINE_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 18;

   // Register offsets, kept as register indices
   localparam logic [31:0] OFS_BASE = 32'h5000_0100;
   localparam logic [31:0] OFS_CONTROL = 32'h5000_0100;
   localparam logic [31:0] OFS_COMPARE = 32'h5000_0102;
   localparam logic [31:0] OFS_IRQ_STATUS = 32'h5000_0104;
   localparam logic [31:0] OFS_EVENT_COUNTS = 32'h5000_0106;
   localparam logic [31:0] OFS_PORT0_SELECT = 32'h5000_0108;
   localparam logic [31:0] OFS_PORT1_SELECT = 32'h5000_010a;
   localparam logic [31:0] OFS_PORT0_POLARITY = 32'h5000_010c;
   localparam logic [31:0] OFS_PORT1_POLARITY = 32'h5000_010e;

   // Byte address inside the slave window: four times the index
   function automatic logic [7:0] byte_addr(input logic [31:0] ofs);
      logic [31:0] idx;
      idx = ofs - OFS_BASE;
      return idx[5:0] * 8'h04;
   endfunction

   localparam logic [7:0] ADDR_CONTROL = byte_addr(OFS_CONTROL);
   localparam logic [7:0] ADDR_COMPARE = byte_addr(OFS_COMPARE);
   localparam logic [7:0] ADDR_IRQ_STATUS = byte_addr(OFS_IRQ_STATUS);
   localparam logic [7:0] ADDR_EVENT_COUNTS = byte_addr(OFS_EVENT_COUNTS);
   localparam logic [7:0] ADDR_PORT0_SELECT = byte_addr(OFS_PORT0_SELECT);
   localparam logic [7:0] ADDR_PORT1_SELECT = byte_addr(OFS_PORT1_SELECT);
   localparam logic [7:0] ADDR_PORT0_POLARITY = byte_addr(OFS_PORT0_POLARITY);
   localparam logic [7:0] ADDR_PORT1_POLARITY = byte_addr(OFS_PORT1_POLARITY);

   // Field layout
   localparam int CTL_W = 10;
   localparam int CTL_FINE_BIT = 9;
   localparam int CTL_IRQ2_EN_BIT = 8;
   localparam int CTL_IRQ1_EN_BIT = 7;
   localparam int CTL_SW_KEY_BIT = 6;
   localparam int DEB_W = 6;
   localparam int DEB_LSB = 0;
   localparam int ST_PEND1_BIT = 0;
   localparam int ST_PEND2_BIT = 1;
   localparam int ST_CLR1_BIT = 2;
   localparam int ST_CLR2_BIT = 3;
   localparam int CNT_W = 8;
   localparam int CNT2_LSB = 8;
   localparam int PORT_W = 12;

   // Values after reset
   localparam logic [CTL_W-1:0] CONTROL_RESET = 10'h000;
   localparam logic [CNT_W-1:0] COMPARE_RESET = 8'h00;
   localparam logic [CNT_W-1:0] COUNT_RESET = 8'h00;
   localparam logic [PORT_W-1:0] PORT_RESET = 12'h000;
   localparam logic [DEB_W-1:0] DEB_RESET = 6'h00;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_READ_WAIT = 2'b01,
      BUS_READ_DONE = 2'b11
   } bus_phase_t;
endpackage

// *** src/wakeup_event_counter.sv ***
// Wake-up unit: debounced pin and software events feeding two compare counters
//
// What this block does
// [RULE_01] Control bit picks 1 ms or 125 us step
// [RULE_02] Zero steps bypasses debounce, else N steps stable
// [RULE_03] First counter match raises first interrupt if enabled
// [RULE_04] Second counter match raises second interrupt if enabled
// [RULE_05] Compare holds event count minus one
// [RULE_06] Software key hit bumps both counters once
// [RULE_07] Software must clear key hit before next hit
// [RULE_08] Write one clears first counter, reads zero
// [RULE_09] Write one clears second counter, reads zero
// [RULE_10] First pending bit readable, write one clears
// [RULE_11] Second pending bit readable, write one clears
// [RULE_12] Counts register: second high byte, first low
// [RULE_13] Port-zero mask enables first counter sources
// [RULE_14] Port-one mask enables second counter sources
// [RULE_15] Port-zero polarity: clear high-going, set low-going
// [RULE_16] Port-one polarity: clear high-going, set low-going
// [RULE_17] Pending stays until cleared; controls reset zero
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
module wakeup_event_counter
#(
   parameter int UNIT_COARSE = wakeup_pkg::UNIT_COARSE_CYCLES,
   parameter int UNIT_FINE = wakeup_pkg::UNIT_FINE_CYCLES
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [11:0] port_zero_input,
   input wire logic [11:0] port_one_input,
   output logic first_wakeup_irq,
   output logic second_wakeup_irq
);

   localparam int CW = wakeup_pkg::CNT_W;
   localparam int PW = wakeup_pkg::PORT_W;
   localparam logic [wakeup_pkg::TICK_W-1:0] COARSE_LAST = wakeup_pkg::TICK_W'(UNIT_COARSE - 1);
   localparam logic [wakeup_pkg::TICK_W-1:0] FINE_LAST = wakeup_pkg::TICK_W'(UNIT_FINE - 1);

   // Any enabled input at its active level; polarity set means low is active
   function automatic logic port_active(input logic [11:0] pins, input logic [11:0] mask,
                                        input logic [11:0] pol);
      return |((pins ^ pol) & mask);
   endfunction

   // Registers
   logic [wakeup_pkg::CTL_W-1:0] wakeup_control;
   logic [CW-1:0] wakeup_compare;
   logic [PW-1:0] wakeup_port0_select;
   logic [PW-1:0] wakeup_port1_select;
   logic [PW-1:0] wakeup_port0_polarity;
   logic [PW-1:0] wakeup_port1_polarity;
   logic first_irq_pending;
   logic second_irq_pending;
   logic [CW-1:0] first_count_value;
   logic [CW-1:0] second_count_value;

   // Control fields
   wire logic fine_debounce_unit_sel = wakeup_control[wakeup_pkg::CTL_FINE_BIT];
   wire logic first_counter_irq_en = wakeup_control[wakeup_pkg::CTL_IRQ1_EN_BIT];
   wire logic second_counter_irq_en = wakeup_control[wakeup_pkg::CTL_IRQ2_EN_BIT];
   wire logic software_key_hit = wakeup_control[wakeup_pkg::CTL_SW_KEY_BIT];
   wire logic [wakeup_pkg::DEB_W-1:0] debounce_steps =
      wakeup_control[wakeup_pkg::DEB_LSB +: wakeup_pkg::DEB_W];

   // Pin synchronisers
   logic [PW-1:0] p0_meta;
   logic [PW-1:0] p0_sync;
   logic [PW-1:0] p1_meta;
   logic [PW-1:0] p1_sync;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         p0_meta <= wakeup_pkg::PORT_RESET;
         p0_sync <= wakeup_pkg::PORT_RESET;
         p1_meta <= wakeup_pkg::PORT_RESET;
         p1_sync <= wakeup_pkg::PORT_RESET;
      end
      else
      begin
         p0_meta <= port_zero_input;
         p0_sync <= p0_meta;
         p1_meta <= port_one_input;
         p1_sync <= p1_meta;
      end
   end

   // Debounce time base
   logic [wakeup_pkg::TICK_W-1:0] tick_count;
   wire logic [wakeup_pkg::TICK_W-1:0] tick_last = fine_debounce_unit_sel ? FINE_LAST : COARSE_LAST; // RULE_01
   wire logic unit_tick = (tick_count >= tick_last);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         tick_count <= '0;
      else if (unit_tick)
         tick_count <= '0;
      else
         tick_count <= tick_count + 1'b1;
   end

   // Raw event levels; the software hit feeds both channels
   wire logic raw1 = port_active(p0_sync, wakeup_port0_select, wakeup_port0_polarity) // RULE_13 RULE_15
                     | software_key_hit; // RULE_06
   wire logic raw2 = port_active(p1_sync, wakeup_port1_select, wakeup_port1_polarity) // RULE_14 RULE_16
                     | software_key_hit; // RULE_06
   wire logic [1:0] raw = {raw2, raw1};

   // Debounce filters: a change is accepted on the debounce_steps-th unit tick after it
   logic [1:0] deb_level;
   logic [1:0] deb_prev;
   logic [wakeup_pkg::DEB_W-1:0] deb_units [2];
   logic [1:0] deb_next;

   for (genvar g = 0; g < 2; g++)
   begin : g_deb
      wire logic settled = (deb_units[g] + 1'b1 >= debounce_steps) && unit_tick;
      assign deb_next[g] = (debounce_steps == wakeup_pkg::DEB_RESET) ? raw[g] : // RULE_02
                           (raw[g] != deb_level[g] && settled) ? raw[g] : deb_level[g]; // RULE_02

      always_ff @(posedge hclk or negedge hresetn)
      begin
         if (!hresetn)
            deb_units[g] <= wakeup_pkg::DEB_RESET;
         else if (raw[g] == deb_level[g] || debounce_steps == wakeup_pkg::DEB_RESET)
            deb_units[g] <= wakeup_pkg::DEB_RESET;
         else if (unit_tick)
            deb_units[g] <= deb_units[g] + 1'b1; // RULE_02
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         deb_level <= 2'h0;
         deb_prev <= 2'h0;
      end
      else
      begin
         deb_level <= deb_next;
         deb_prev <= deb_level;
      end
   end

   // One event per rising edge of the filtered level; the key hit must drop first
   wire logic event1 = deb_level[0] & ~deb_prev[0]; // RULE_07
   wire logic event2 = deb_level[1] & ~deb_prev[1]; // RULE_07
   wire logic match1 = event1 && (first_count_value == wakeup_compare); // RULE_05
   wire logic match2 = event2 && (second_count_value == wakeup_compare); // RULE_05

   // AHB-Lite slave: writes zero wait, reads one wait so hrdata is registered
   wakeup_pkg::bus_phase_t bus_phase;
   wakeup_pkg::bus_phase_t next_bus_phase;
   logic wr_pend;
   logic [7:0] dp_addr;

   wire logic take = hsel && htrans[1] && hready;
   wire logic take_rd = take && !hwrite;
   wire logic take_wr = take && hwrite;
   // Only whole-word writes land; narrower stores are dropped
   wire logic word_access = (hsize == 3'h2);

   assign hreadyout = (bus_phase != wakeup_pkg::BUS_READ_WAIT);
   assign hresp = 1'b0;

   always_comb
   begin
      case (bus_phase)
         wakeup_pkg::BUS_IDLE,
         wakeup_pkg::BUS_READ_DONE: next_bus_phase = take_rd ? wakeup_pkg::BUS_READ_WAIT : wakeup_pkg::BUS_IDLE;
         wakeup_pkg::BUS_READ_WAIT: next_bus_phase = wakeup_pkg::BUS_READ_DONE;
         default: next_bus_phase = wakeup_pkg::BUS_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bus_phase <= wakeup_pkg::BUS_IDLE;
         wr_pend <= 1'b0;
         dp_addr <= 8'h00;
      end
      else
      begin
         bus_phase <= next_bus_phase;
         if (hready)
            wr_pend <= take_wr && word_access;
         if (take)
            dp_addr <= haddr[7:0];
      end
   end

   // Write strobes in the data phase
   wire logic wr_control = wr_pend && dp_addr == wakeup_pkg::ADDR_CONTROL;
   wire logic wr_compare = wr_pend && dp_addr == wakeup_pkg::ADDR_COMPARE;
   wire logic wr_status = wr_pend && dp_addr == wakeup_pkg::ADDR_IRQ_STATUS;
   wire logic wr_sel0 = wr_pend && dp_addr == wakeup_pkg::ADDR_PORT0_SELECT;
   wire logic wr_sel1 = wr_pend && dp_addr == wakeup_pkg::ADDR_PORT1_SELECT;
   wire logic wr_pol0 = wr_pend && dp_addr == wakeup_pkg::ADDR_PORT0_POLARITY;
   wire logic wr_pol1 = wr_pend && dp_addr == wakeup_pkg::ADDR_PORT1_POLARITY;
   wire logic clr_pend1 = wr_status && hwdata[wakeup_pkg::ST_PEND1_BIT];
   wire logic clr_pend2 = wr_status && hwdata[wakeup_pkg::ST_PEND2_BIT];
   wire logic clr_cnt1 = wr_status && hwdata[wakeup_pkg::ST_CLR1_BIT];
   wire logic clr_cnt2 = wr_status && hwdata[wakeup_pkg::ST_CLR2_BIT];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wakeup_control <= wakeup_pkg::CONTROL_RESET; // RULE_17
         wakeup_compare <= wakeup_pkg::COMPARE_RESET;
         wakeup_port0_select <= wakeup_pkg::PORT_RESET;
         wakeup_port1_select <= wakeup_pkg::PORT_RESET;
         wakeup_port0_polarity <= wakeup_pkg::PORT_RESET;
         wakeup_port1_polarity <= wakeup_pkg::PORT_RESET;
      end
      else
      begin
         if (wr_control)
            wakeup_control <= hwdata[wakeup_pkg::CTL_W-1:0];
         if (wr_compare)
            wakeup_compare <= hwdata[CW-1:0];
         if (wr_sel0)
            wakeup_port0_select <= hwdata[PW-1:0]; // RULE_13
         if (wr_sel1)
            wakeup_port1_select <= hwdata[PW-1:0]; // RULE_14
         if (wr_pol0)
            wakeup_port0_polarity <= hwdata[PW-1:0]; // RULE_15
         if (wr_pol1)
            wakeup_port1_polarity <= hwdata[PW-1:0]; // RULE_16
      end
   end

   // Counters: the clear beats a coincident event, so software sees zero afterwards
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         first_count_value <= wakeup_pkg::COUNT_RESET;
         second_count_value <= wakeup_pkg::COUNT_RESET;
      end
      else
      begin
         if (clr_cnt1)
            first_count_value <= wakeup_pkg::COUNT_RESET; // RULE_08
         else if (event1)
            first_count_value <= first_count_value + 1'b1; // RULE_06
         if (clr_cnt2)
            second_count_value <= wakeup_pkg::COUNT_RESET; // RULE_09
         else if (event2)
            second_count_value <= second_count_value + 1'b1; // RULE_06
      end
   end

   // Pending flags: a new match wins over a write-one clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         first_irq_pending <= 1'b0;
         second_irq_pending <= 1'b0;
      end
      else
      begin
         if (match1 && first_counter_irq_en)
            first_irq_pending <= 1'b1; // RULE_03
         else if (clr_pend1)
            first_irq_pending <= 1'b0; // RULE_10 RULE_17
         if (match2 && second_counter_irq_en)
            second_irq_pending <= 1'b1; // RULE_04
         else if (clr_pend2)
            second_irq_pending <= 1'b0; // RULE_11 RULE_17
      end
   end

   assign first_wakeup_irq = first_irq_pending; // RULE_03
   assign second_wakeup_irq = second_irq_pending; // RULE_04

   // Read mux; clear bits always read zero
   logic [31:0] rd_mux;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (dp_addr)
         wakeup_pkg::ADDR_CONTROL: rd_mux[wakeup_pkg::CTL_W-1:0] = wakeup_control;
         wakeup_pkg::ADDR_COMPARE: rd_mux[CW-1:0] = wakeup_compare;
         wakeup_pkg::ADDR_IRQ_STATUS:
         begin
            rd_mux[wakeup_pkg::ST_PEND1_BIT] = first_irq_pending; // RULE_10
            rd_mux[wakeup_pkg::ST_PEND2_BIT] = second_irq_pending; // RULE_11
         end
         wakeup_pkg::ADDR_EVENT_COUNTS: rd_mux[15:0] = {second_count_value, first_count_value}; // RULE_12
         wakeup_pkg::ADDR_PORT0_SELECT: rd_mux[PW-1:0] = wakeup_port0_select;
         wakeup_pkg::ADDR_PORT1_SELECT: rd_mux[PW-1:0] = wakeup_port1_select;
         wakeup_pkg::ADDR_PORT0_POLARITY: rd_mux[PW-1:0] = wakeup_port0_polarity;
         wakeup_pkg::ADDR_PORT1_POLARITY: rd_mux[PW-1:0] = wakeup_port1_polarity;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (bus_phase == wakeup_pkg::BUS_READ_WAIT)
         hrdata <= rd_mux;
   end

endmodule // wakeup_event_counter

// *** tb/wakeup_event_counter_asserts.sv ***
// Checker on the wake-up counter bus and interrupt ports
`timescale 1ns/1ps
module wakeup_event_counter_asserts
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic first_wakeup_irq,
   input wire logic second_wakeup_irq
);
   logic wr_st;
   wire acc = hsel && htrans[1] && hready;
   wire rd = acc && !hwrite;
   wire [7:0] a = haddr[7:0];
   wire clr1 = wr_st && hwdata[0];
   wire clr2 = wr_st && hwdata[1];
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wr_st <= 1'b0;
      else
         wr_st <= acc && hwrite && a == wakeup_pkg::ADDR_IRQ_STATUS;
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_rd_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("bus response not okay");
   property p_wr_wait; acc && hwrite |=> hreadyout; endproperty
   a_wr_wait: assert property (p_wr_wait) else $error("write stalled");
   property p_rd_wait; rd |=> s_rd_wait; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait not one cycle");
   property p_clr1; $fell(first_wakeup_irq) |-> $past(clr1); endproperty
   a_clr1: assert property (p_clr1) else $error("first irq dropped uncleared");
   property p_clr2; $fell(second_wakeup_irq) |-> $past(clr2); endproperty
   a_clr2: assert property (p_clr2) else $error("second irq dropped uncleared");
   property p_st_rd; rd && a == wakeup_pkg::ADDR_IRQ_STATUS |-> ##2 hrdata[31:2] == 30'h0; endproperty
   a_st_rd: assert property (p_st_rd) else $error("status clear bits read nonzero");
   property p_unmapped; rd && (a[2:0] != 3'h0 || a[7:6] != 2'h0) |-> ##2 hrdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
   property p_counts; rd && a == wakeup_pkg::ADDR_EVENT_COUNTS |-> ##2 hrdata[31:16] == 16'h0; endproperty
   a_counts: assert property (p_counts) else $error("counts upper half nonzero");
endmodule // wakeup_event_counter_asserts
bind wakeup_event_counter wakeup_event_counter_asserts u_asserts (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .first_wakeup_irq(first_wakeup_irq),
   .second_wakeup_irq(second_wakeup_irq));

// *** tb/key_contacts.sv ***
// Key and switch contacts on the two wake-up ports
`timescale 1ns/1ps
module key_contacts
(
   input wire logic hclk,
   input wire logic [23:0] press,
   input wire logic [23:0] rest_high,
   input wire logic [3:0] chatter,
   output logic [11:0] port_zero_input,
   output logic [11:0] port_one_input
);
   logic [23:0] held = 24'h0;
   logic [23:0] old = 24'h0;
   logic [23:0] lvl = 24'h0;
   logic [3:0] left = 4'h0;
   // Contacts bounce: odd chatter cycles fall back to the old level
   always @(posedge hclk)
   begin
      if (press != held)
      begin
         old <= held;
         held <= press;
         left <= chatter;
      end
      else if (left != 4'h0)
         left <= left - 4'h1;
      lvl <= left[0] ? old : held;
   end
   // Normally closed contacts rest high and open when pressed
   assign {port_one_input, port_zero_input} = lvl ^ rest_high;
endmodule // key_contacts

// *** tb/wakeup_event_counter_tb.sv ***
// Self-checking bench for the wake-up event counter
`timescale 1ns/1ps
module wakeup_event_counter_tb;
   localparam logic [7:0] CTL = wakeup_pkg::ADDR_CONTROL;
   localparam logic [7:0] CMP = wakeup_pkg::ADDR_COMPARE;
   localparam logic [7:0] ST = wakeup_pkg::ADDR_IRQ_STATUS;
   localparam logic [7:0] CNT = wakeup_pkg::ADDR_EVENT_COUNTS;
   localparam logic [7:0] S0 = wakeup_pkg::ADDR_PORT0_SELECT;
   localparam logic [7:0] S1 = wakeup_pkg::ADDR_PORT1_SELECT;
   localparam logic [7:0] P0 = wakeup_pkg::ADDR_PORT0_POLARITY;
   localparam logic [7:0] P1 = wakeup_pkg::ADDR_PORT1_POLARITY;
   localparam logic [7:0] ra [8] = '{CMP, S0, S1, P0, P1, CNT, 8'h04, CTL};
   localparam logic [31:0] rw [8] = '{32'hffff_ff5a, 32'hffff_ffdf, 32'h0000_0a5a, 32'hffff_f0f0,
      32'h0000_0123, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_fe3f};
   localparam logic [31:0] rx [8] = '{32'h5a, 32'hfdf, 32'ha5a, 32'h0f0, 32'h123, 32'h0, 32'h0, 32'h23f};
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, irq1, irq2;
   logic [31:0] hrdata, rv;
   logic [11:0] p0_pins, p1_pins;
   logic [23:0] press = 24'h0;
   logic [3:0] chatter = 4'h0;
   logic [7:0] e1 = 8'h0;
   logic [7:0] e2 = 8'h0;
   int mismatches = 0;
   int checks = 0;
   wakeup_event_counter #(.UNIT_COARSE(20), .UNIT_FINE(5)) uut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .port_zero_input(p0_pins), .port_one_input(p1_pins), .first_wakeup_irq(irq1),
      .second_wakeup_irq(irq2));
   key_contacts keys (.hclk(hclk), .press(press), .rest_high(24'h001020), .chatter(chatter),
      .port_zero_input(p0_pins), .port_one_input(p1_pins));
   always #2 hclk = ~hclk;
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(negedge hclk); while (hreadyout !== 1'b1);
      @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      @(posedge hclk);
      rv = hrdata;
   endtask
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_irq(input logic exp);
      @(negedge hclk);
      chk_reg({30'h0, irq2, irq1}, exp ? 32'h3 : 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk_reg(rv, exp);
   endtask
   task automatic cnt_chk;
      rd_chk(CNT, {16'h0, e2, e1});
   endtask
   task automatic tap(input int b, input int n);
      press[b] <= 1'b1;
      repeat (n) @(posedge hclk);
      press[b] <= 1'b0;
      repeat (n) @(posedge hclk);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 8; i++)
         rd_chk(ra[i], 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         wr(ra[i], rw[i]);
         rd_chk(ra[i], rx[i]);
         wr(ra[i], 32'h0);
      end
      // Polarity before select, so no spurious edge on enabling
      wr(P0, 32'h020);
      wr(S0, 32'h028);
      wr(CMP, 32'h1);
      wr(CTL, 32'h080);
      tap(3, 12);
      tap(4, 12);
      e1 = 8'h1;
      cnt_chk;
      chk_irq(1'b0);
      tap(5, 12);
      e1 = 8'h2;
      chk_reg({30'h0, irq2, irq1}, 32'h1);
      tap(3, 12);
      e1 = 8'h3;
      cnt_chk;
      rd_chk(ST, 32'h1);
      wr(ST, 32'h1);
      chk_irq(1'b0);
      wr(ST, 32'h4);
      e1 = 8'h0;
      cnt_chk;
      wr(P1, 32'h001);
      wr(S1, 32'h001);
      wr(CMP, 32'h0);
      wr(CTL, 32'h100);
      tap(12, 12);
      chk_reg({30'h0, irq2, irq1}, 32'h2);
      e2 = 8'h1;
      cnt_chk;
      rd_chk(ST, 32'h2);
      wr(ST, 32'ha);
      e2 = 8'h0;
      chk_irq(1'b0);
      cnt_chk;
      wr(CTL, 32'h040);
      repeat (10) @(posedge hclk);
      wr(CTL, 32'h0);
      e1 = 8'h1;
      e2 = 8'h1;
      cnt_chk;
      chk_irq(1'b0);
      wr(CTL, 32'h003);
      press[3] <= 1'b1;
      repeat (30) @(posedge hclk);
      cnt_chk;
      repeat (60) @(posedge hclk);
      e1 = 8'h2;
      cnt_chk;
      press[3] <= 1'b0;
      repeat (80) @(posedge hclk);
      wr(CTL, 32'h203);
      chatter <= 4'h3;
      tap(3, 3);
      tap(3, 40);
      e1 = 8'h3;
      cnt_chk;
      hresetn <= 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      e1 = 8'h0;
      e2 = 8'h0;
      cnt_chk;
      rd_chk(CTL, 32'h0);
      test_done;
   end
   initial
   begin
      #100000;
      mismatches++;
      test_done;
   end
endmodule // wakeup_event_counter_tb
